// *** epi_defines.vh ***
// constants for the external pin interrupt and vector priority block
`ifndef EPI_DEFINES_VH
`define EPI_DEFINES_VH

// register byte offsets
`define EPI_OFS_PIN_CTRL   12'h000
`define EPI_OFS_SRC_EN     12'h004
`define EPI_OFS_GMASK      12'h008
`define EPI_OFS_EVT_STAT   12'h00C
`define EPI_OFS_EVT_MASK   12'h010
`define EPI_OFS_VEC_STAT   12'h014

// pin control register fields
`define EPI_PC_ENABLE      0
`define EPI_PC_LEVEL_SEL   1
`define EPI_PC_IRQ_EN      2
`define EPI_PC_PULLUP_DIS  3
`define EPI_PC_ACK         4
`define EPI_PC_PENDING     5
`define EPI_PC_PIN_LEVEL   6

// event status fields
`define EPI_EV_PIN         0
`define EPI_EV_TAKEN       1
`define EPI_EV_WAKE        2
`define EPI_EV_W           3

// vector status fields
`define EPI_VS_NUM_LO      0
`define EPI_VS_NUM_HI      4
`define EPI_VS_ANY         8
`define EPI_VS_GMASK       9

// global mask register field
`define EPI_GM_SET         0

// reset values
`define EPI_RST_PIN_CTRL   4'h0
`define EPI_RST_SRC_EN     32'h00000000
`define EPI_RST_GMASK      1'b1
`define EPI_RST_EVT_MASK   3'h0

// vector map
`define EPI_VEC_PIN        2
`define EPI_VEC_NOT_REQ    32'hFF000803
`define EPI_VEC_TOP        16'hFFFE
`define EPI_NUM_W          5
`define EPI_NSRC           32

// stacking order
`define EPI_STK_PCL        3'h0
`define EPI_STK_PCH        3'h1
`define EPI_STK_X          3'h2
`define EPI_STK_A          3'h3
`define EPI_STK_CCR        3'h4
`define EPI_STK_LAST       3'h4

`endif

// *** epi_sync.v ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
module epi_sync #(
   parameter RST_VAL = 1'b1
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // level in and out
   input wire d,
   output wire q
);
   reg meta_q;
   reg sync_q;

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule // epi_sync

// *** epi_prio_enc.v ***
// fixed priority encoder, lowest index wins
`timescale 1ns/10ps
module epi_prio_enc #(
   parameter N = 32,
   parameter W = 5
) (
   // requests
   input wire [N-1:0] req,
   // winner
   output reg any,
   output reg [W-1:0] num
);
   integer i;

   always @*
   begin
      any = 1'b0;
      num = {W{1'b0}};
      for (i = N - 1; i >= 0; i = i - 1)
      begin
         if (req[i])
         begin
            any = 1'b1;
            num = i[W-1:0];
         end
      end
   end
endmodule // epi_prio_enc

// *** epi_irq_top.v ***
// external pin interrupt, stacking sequence and vector selection
//
// Contract
// - pin raises events only while enabled
// - pin sampled synchronously on system clock
// - asynchronous path wakes device from stop
// - mode bit selects edge or edge-and-level
// - pin event may interrupt or only flag
// - pullup on unless pullup disable bit set; here on only while the pin enable bit is also set
// - pin level visible to cpu branch tests
// - level mode: flag sticks while pin low
// - flags set always, forwarded when enabled
// - push five registers, set mask, fetch vector
// - vector high byte first, low next
// - fixed priority, lower vector number wins
// - unused vector numbers never request
// - global mask set after any reset
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "epi_defines.vh"
module epi_irq_top (
   // clock and reset
   input wire clock,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // external pin, active low
   input wire irq_pin_n,
   output reg pullup_en_q,
   // other sources
   input wire [31:0] src_flag,
   // cpu side
   input wire instr_done,
   input wire mask_clear,
   input wire stop_mode,
   output reg pin_level_q,
   output reg gmask_q,
   output reg stack_push_q,
   output reg [2:0] stack_sel_q,
   output reg vec_rd_q,
   output reg [15:0] vec_addr_q,
   output reg [4:0] vec_num_q,
   output reg isr_enter_q,
   // wake and interrupt
   output reg stop_wake_q,
   output reg irq_q
);
   localparam ST_IDLE = 3'h0;
   localparam ST_PUSH = 3'h1;
   localparam ST_VHI = 3'h2;
   localparam ST_VLO = 3'h3;
   localparam ST_ENTER = 3'h4;
   localparam [31:0] NOT_REQ = `EPI_VEC_NOT_REQ;

   reg pin_en_q;
   reg level_sel_q;
   reg pin_irq_en_q;
   reg pullup_dis_q;
   reg pending_q;
   reg pin_prev_q;
   reg [31:0] src_en_q;
   reg [2:0] evt_stat_q;
   reg [2:0] evt_mask_q;
   reg [2:0] state_q;
   reg [2:0] cnt_q;
   reg wake_prev_q;
   reg async_wake_q;
   wire pin_s;
   wire wake_s;
   wire any;
   wire [4:0] win;
   wire acc;
   wire wr;
   wire rd;
   wire fall;
   wire pin_set;
   wire ack;
   wire [31:0] req;
   wire [2:0] ev;
   reg [31:0] rdata_d;
   reg map_ok;

   function sel;
      input [11:0] a;
      input [11:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin sampling
   epi_sync #(.RST_VAL(1'b1)) u_pin_sync (
      .clock(clock),
      .rst(rst),
      .d(irq_pin_n),
      .q(pin_s)
   );

   assign fall = pin_en_q & pin_prev_q & ~pin_s;
   // level mode keeps setting while low
   assign pin_set = pin_en_q & (fall | (level_sel_q & ~pin_s));
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign ack = wr & sel(paddr, `EPI_OFS_PIN_CTRL) & pwdata[`EPI_PC_ACK];

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pin_prev_q <= 1'b1;
         pending_q <= 1'b0;
         pin_level_q <= 1'b1;
         pullup_en_q <= 1'b0;
      end
      else
      begin
         pin_prev_q <= pin_s;
         // set wins over acknowledge
         if (pin_set)
            pending_q <= 1'b1;
         else if (ack)
            pending_q <= 1'b0;
         pin_level_q <= pin_en_q ? pin_s : 1'b1;
         pullup_en_q <= pin_en_q & ~pullup_dis_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // asynchronous wake in stop
   always @(negedge irq_pin_n or posedge rst)
   begin
      if (rst)
         async_wake_q <= 1'b0;
      else
         async_wake_q <= pin_en_q & stop_mode;
   end

   epi_sync #(.RST_VAL(1'b0)) u_wake_sync (
      .clock(clock),
      .rst(rst),
      .d(async_wake_q),
      .q(wake_s)
   );

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stop_wake_q <= 1'b0;
         wake_prev_q <= 1'b0;
      end
      else
      begin
         stop_wake_q <= wake_s;
         wake_prev_q <= wake_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request qualification and priority
   genvar g;
   generate
      for (g = 0; g < `EPI_NSRC; g = g + 1)
      begin : g_req
         if (g == `EPI_VEC_PIN)
         begin : g_pin
            assign req[g] = pending_q & pin_irq_en_q;
         end
         else
         begin : g_src
            assign req[g] = src_flag[g] & src_en_q[g] & ~NOT_REQ[g];
         end
      end
   endgenerate

   epi_prio_enc #(.N(`EPI_NSRC), .W(`EPI_NUM_W)) u_prio (
      .req(req),
      .any(any),
      .num(win)
   );

   ////////////////////////////////////////////////////////////////////////
   // stacking and vector fetch
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= `EPI_STK_PCL;
         gmask_q <= `EPI_RST_GMASK;
         stack_push_q <= 1'b0;
         stack_sel_q <= `EPI_STK_PCL;
         vec_rd_q <= 1'b0;
         vec_addr_q <= `EPI_VEC_TOP;
         vec_num_q <= {`EPI_NUM_W{1'b0}};
         isr_enter_q <= 1'b0;
      end
      else
      begin
         stack_push_q <= 1'b0;
         vec_rd_q <= 1'b0;
         isr_enter_q <= 1'b0;
         if (mask_clear | (wr & sel(paddr, `EPI_OFS_GMASK) & ~pwdata[`EPI_GM_SET]))
            gmask_q <= 1'b0;
         else if (wr & sel(paddr, `EPI_OFS_GMASK))
            gmask_q <= 1'b1;
         case (state_q)
            ST_IDLE:
            begin
               if (any & ~gmask_q & instr_done)
               begin
                  state_q <= ST_PUSH;
                  cnt_q <= `EPI_STK_PCL;
               end
            end
            ST_PUSH:
            begin
               stack_push_q <= 1'b1;
               stack_sel_q <= cnt_q;
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == `EPI_STK_LAST)
               begin
                  gmask_q <= 1'b1;
                  vec_num_q <= win;
                  state_q <= ST_VHI;
               end
            end
            ST_VHI:
            begin
               vec_rd_q <= 1'b1;
               vec_addr_q <= `EPI_VEC_TOP - {10'h000, vec_num_q, 1'b0};
               state_q <= ST_VLO;
            end
            ST_VLO:
            begin
               vec_rd_q <= 1'b1;
               vec_addr_q <= vec_addr_q + 16'h0001;
               state_q <= ST_ENTER;
            end
            ST_ENTER:
            begin
               isr_enter_q <= 1'b1;
               state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb registers
   always @*
   begin
      rdata_d = 32'h00000000;
      map_ok = 1'b1;
      if (sel(paddr, `EPI_OFS_PIN_CTRL))
      begin
         rdata_d[`EPI_PC_ENABLE] = pin_en_q;
         rdata_d[`EPI_PC_LEVEL_SEL] = level_sel_q;
         rdata_d[`EPI_PC_IRQ_EN] = pin_irq_en_q;
         rdata_d[`EPI_PC_PULLUP_DIS] = pullup_dis_q;
         rdata_d[`EPI_PC_PENDING] = pending_q;
         rdata_d[`EPI_PC_PIN_LEVEL] = pin_level_q;
      end
      else if (sel(paddr, `EPI_OFS_SRC_EN))
         rdata_d = src_en_q;
      else if (sel(paddr, `EPI_OFS_GMASK))
         rdata_d[`EPI_GM_SET] = gmask_q;
      else if (sel(paddr, `EPI_OFS_EVT_STAT))
         rdata_d[`EPI_EV_W-1:0] = evt_stat_q;
      else if (sel(paddr, `EPI_OFS_EVT_MASK))
         rdata_d[`EPI_EV_W-1:0] = evt_mask_q;
      else if (sel(paddr, `EPI_OFS_VEC_STAT))
      begin
         rdata_d[`EPI_VS_NUM_HI:`EPI_VS_NUM_LO] = win;
         rdata_d[`EPI_VS_ANY] = any;
         rdata_d[`EPI_VS_GMASK] = gmask_q;
      end
      else
         map_ok = 1'b0;
   end

   assign ev = {wake_s & ~wake_prev_q, isr_enter_q, pin_set & ~pending_q};

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pin_en_q <= 1'b0;
         level_sel_q <= 1'b0;
         pin_irq_en_q <= 1'b0;
         pullup_dis_q <= 1'b0;
         src_en_q <= `EPI_RST_SRC_EN;
         evt_stat_q <= 3'h0;
         evt_mask_q <= `EPI_RST_EVT_MASK;
         irq_q <= 1'b0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~map_ok;
         if (psel & penable & ~pready)
            prdata <= rdata_d;
         if (wr & sel(paddr, `EPI_OFS_PIN_CTRL))
         begin
            pin_en_q <= pwdata[`EPI_PC_ENABLE];
            level_sel_q <= pwdata[`EPI_PC_LEVEL_SEL];
            pin_irq_en_q <= pwdata[`EPI_PC_IRQ_EN];
            pullup_dis_q <= pwdata[`EPI_PC_PULLUP_DIS];
         end
         if (wr & sel(paddr, `EPI_OFS_SRC_EN))
            src_en_q <= pwdata;
         if (wr & sel(paddr, `EPI_OFS_EVT_MASK))
            evt_mask_q <= pwdata[`EPI_EV_W-1:0];
         // read clears, new events win
         if (rd & sel(paddr, `EPI_OFS_EVT_STAT))
            evt_stat_q <= ev;
         else
            evt_stat_q <= evt_stat_q | ev;
         irq_q <= |(evt_stat_q & evt_mask_q);
      end
   end
endmodule // epi_irq_top

// *** epi_irq_top_asserts.sv ***
// assertions on the pin interrupt block ports
`timescale 1ns/10ps
module epi_irq_chk (
   // clock and reset
   input wire clock,
   input wire rst,
   // bus and cpu inputs
   input wire psel,
   input wire pwrite,
   input wire mask_clear,
   // sequence outputs
   input wire gmask_q,
   input wire stack_push_q,
   input wire [2:0] stack_sel_q,
   input wire vec_rd_q,
   input wire [15:0] vec_addr_q,
   input wire [4:0] vec_num_q,
   input wire isr_enter_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   //////////////////////////////
   a_mask_reset: assert property ($fell(rst) |-> gmask_q)
      else $error("mask low after reset");
   a_mask_hold: assert property (gmask_q && !mask_clear
      && !(psel && pwrite) |=> gmask_q) else $error("mask dropped");
   a_push_start: assert property ($rose(stack_push_q)
      |-> stack_sel_q == 3'h0 && !$past(gmask_q, 2)) else $error("bad start");
   a_push_order: assert property (stack_push_q && stack_sel_q != 3'h4
      |=> stack_push_q && stack_sel_q == $past(stack_sel_q) + 3'h1) else $error("order");
   a_push_vec: assert property (stack_push_q && stack_sel_q == 3'h4
      |=> !stack_push_q && gmask_q && vec_rd_q) else $error("no vector");
   a_vec_addr: assert property ($rose(vec_rd_q)
      |-> vec_addr_q == 16'hFFFE - {10'h0, vec_num_q, 1'b0} ##1 vec_rd_q
      && vec_addr_q == $past(vec_addr_q) + 16'h1) else $error("vector address");
   a_vec_enter: assert property ($rose(vec_rd_q)
      |=> vec_rd_q ##1 !vec_rd_q && isr_enter_q) else $error("no entry");
   a_vec_used: assert property (vec_rd_q |-> vec_num_q > 5'h1
      && vec_num_q != 5'hB && vec_num_q < 5'h18) else $error("unused vector");
endmodule // epi_irq_chk

bind epi_irq_top epi_irq_chk chk_i (.clock, .rst, .psel, .pwrite, .mask_clear, .gmask_q,
   .stack_push_q, .stack_sel_q, .vec_rd_q, .vec_addr_q, .vec_num_q, .isr_enter_q);

// *** epi_cpu_model.sv ***
// cpu core and external pin driver model
`timescale 1ns/10ps
module epi_cpu_model (
   // clock and reset
   input wire clock,
   input wire rst,
   // bench command and block outputs
   input wire pin_low,
   input wire stack_push_q,
   // to the block and bench
   output logic irq_pin_n,
   output logic instr_done,
   output logic [7:0] n_push
);
   logic [1:0] cnt_q;
   //////////////////////////////
   // pin asserted low
   assign irq_pin_n = !pin_low;
   // an instruction ends every fourth cycle
   assign instr_done = cnt_q == 2'h3;
   always @(posedge clock or posedge rst)
      if (rst)
      begin
         cnt_q <= 2'h0;
         n_push <= 8'h0;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         n_push <= n_push + {7'h0, stack_push_q};
      end
endmodule // epi_cpu_model

// *** epi_irq_top_tb.sv ***
// self-checking bench for the pin interrupt block
`timescale 1ns/10ps
`include "epi_defines.vh"
module epi_irq_top_tb;
   localparam PC = `EPI_OFS_PIN_CTRL;
   localparam ES = `EPI_OFS_EVT_STAT;
   logic clock = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pin_low = 1'b0, mask_clear = 1'b0, stop_mode = 1'b0, err;
   logic [31:0] rd, pwdata = 32'h0, src_flag = 32'h0;
   logic [11:0] paddr = 12'h0;
   logic [15:0] va;
   logic [7:0] p0;
   wire [31:0] prdata;
   wire [15:0] vec_addr_q;
   wire [7:0] n_push;
   wire [4:0] vec_num_q;
   wire [2:0] stack_sel_q;
   wire pready, pslverr, irq_pin_n, pullup_en_q, pin_level_q, gmask_q, stack_push_q;
   wire vec_rd_q, isr_enter_q, stop_wake_q, irq_q, instr_done;
   int failures = 0, n_compared = 0;
   //////////////////////////////
   epi_irq_top uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq_pin_n, .pullup_en_q, .src_flag, .instr_done, .mask_clear,
      .stop_mode, .pin_level_q, .gmask_q, .stack_push_q, .stack_sel_q, .vec_rd_q,
      .vec_addr_q, .vec_num_q, .isr_enter_q, .stop_wake_q, .irq_q);
   epi_cpu_model cpu (.clock, .rst, .pin_low, .stack_push_q, .irq_pin_n, .instr_done,
      .n_push);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   task results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task hang(input int k);
      if (k >= 100)
      begin
         failures++;
         results;
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 100 && pready !== 1'b1; k++)
         @(posedge clock);
      hang(k);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (2) @(posedge clock);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task pin(input logic v);
      pin_low <= v;
      repeat (6) @(posedge clock);
   endtask
   task isr(input logic [4:0] n);
      int k;
      va = 16'h0;
      p0 = n_push;
      for (k = 0; k < 100 && isr_enter_q !== 1'b1; k++)
      begin
         @(posedge clock);
         if (vec_rd_q === 1'b1 && va === 16'h0)
            va = vec_addr_q;
      end
      hang(k);
      chk(vec_num_q, n);
      chk(va, 16'hFFFE - 2 * n);
      chk(n_push, p0 + 8'h5);
   endtask
   //////////////////////////////
   initial
      forever #12.5 clock = ~clock;
   initial
   begin
      rst <= 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      rdc(`EPI_OFS_VEC_STAT, 32'h200, 32'h200);
      rdc(`EPI_OFS_SRC_EN, 32'hFFFFFFFF, 32'h0);
      rdc(12'h100, 32'hFFFFFFFF, 32'h0);
      chk(err, 1'b1);
      pin(1'b1);
      rdc(PC, 32'h3F, 32'h0);
      pin(1'b0);
      wr(`EPI_OFS_EVT_MASK, 32'h7);
      wr(PC, 32'hD);
      chk(pullup_en_q, 1'b0);
      wr(PC, 32'h5);
      chk(pullup_en_q, 1'b1);
      pin(1'b1);
      chk(pin_level_q, 1'b0);
      chk(irq_q, 1'b1);
      rdc(ES, 32'h1, 32'h1);
      rdc(ES, 32'h1, 32'h0);
      wr(PC, 32'h15);
      rdc(PC, 32'h20, 32'h0);
      chk(irq_q, 1'b0);
      wr(PC, 32'h7);
      pin(1'b0);
      pin(1'b1);
      wr(PC, 32'h17);
      rdc(PC, 32'h20, 32'h20);
      pin(1'b0);
      wr(PC, 32'h17);
      rdc(PC, 32'h20, 32'h0);
      wr(PC, 32'h0);
      wr(`EPI_OFS_SRC_EN, 32'h010000A0);
      src_flag <= 32'h010000A8;
      p0 = n_push;
      repeat (20) @(posedge clock);
      chk(n_push, p0);
      wr(`EPI_OFS_GMASK, 32'h0);
      isr(5'h5);
      chk(gmask_q, 1'b1);
      rdc(ES, 32'h2, 32'h2);
      src_flag <= 32'h01000088;
      mask_clear <= 1'b1;
      @(posedge clock);
      mask_clear <= 1'b0;
      isr(5'h7);
      src_flag <= 32'h0;
      wr(PC, 32'h1);
      pin(1'b1);
      wr(`EPI_OFS_GMASK, 32'h0);
      p0 = n_push;
      repeat (20) @(posedge clock);
      chk(n_push, p0);
      wr(PC, 32'h5);
      isr(5'h2);
      pin(1'b0);
      stop_mode <= 1'b1;
      wr(PC, 32'h1);
      pin(1'b1);
      chk(stop_wake_q, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rdc(`EPI_OFS_VEC_STAT, 32'h200, 32'h200);
      chk(stop_wake_q, 1'b0);
      chk(pin_level_q, 1'b1);
      results;
   end
endmodule // epi_irq_top_tb
